// ---- scl_pkg.sv ----
package scl_pkg;

   localparam int CLK_PERIOD_NS   = 4;
   // least times round up to whole cycles
   localparam int SPI_HALF_NS     = 500;
   localparam int SPI_HALF_CYC    =
      (SPI_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TWI_QUARTER_NS  = 2500;
   localparam int TWI_QUARTER_CYC =
      (TWI_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int ACK_WAIT_NS     = 2000;
   localparam int ACK_WAIT_CYC    =
      (ACK_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int NUM_CH          = 16;
   localparam int CH_IDX_W        = 4;
   localparam int CH_SPAN         = 80;
   // dwell must exceed the transmitter's whole channel loop
   localparam int DWELL_CYC       = (NUM_CH + 1) * ACK_WAIT_CYC;
   localparam int LF_TICK_NS      = 30517;
   localparam int LF_TICK_CYC     = LF_TICK_NS / CLK_PERIOD_NS;

   localparam logic [15:0] PEER_TIMEOUT_TICKS  = 16'h4000;
   localparam logic [15:0] AUDIO_TIMEOUT_TICKS = 16'h8000;
   localparam logic [15:0] WAKE_PERIOD_TICKS   = 16'h2000;

   localparam int NCFG            = 4;
   localparam int SPI_CMD_BITS    = 24;
   localparam int SPI_TOTAL_BITS  = SPI_CMD_BITS + 8 * (NCFG + 1);
   localparam logic [23:0] SPI_RD_HDR = 24'h030000;
   localparam logic [7:0]  MEM_MARK   = 8'ha5;
   localparam logic [7:0]  TWI_DEV_RD = 8'ha1;
   localparam int CTRL_SLEEP_EN   = 0;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] hop3;
      logic [7:0] hop2;
      logic [7:0] hop1;
   } scl_cfg_s;

   // hop parameter defaults 0x01, 0x12, 0x05; sleep timers off
   localparam scl_cfg_s CFG_DEFAULT = '{ctrl: 8'h00, hop3: 8'h05,
                                        hop2: 8'h12, hop1: 8'h01};

   typedef struct packed {
      logic search;
      logic ack;
      logic start;
   } scl_rf_ev_s;

   typedef enum logic [2:0] {
      ST_SPI_LOAD   = 3'b000,
      ST_TWI_LOAD   = 3'b001,
      ST_LOCATE     = 3'b010,
      ST_SYNC       = 3'b011,
      ST_IDLE       = 3'b100,
      ST_POWER_DOWN = 3'b101
   } scl_state_e;

   typedef enum logic [1:0] {
      TW_IDLE  = 2'b00,
      TW_START = 2'b01,
      TW_BITS  = 2'b10,
      TW_STOP  = 2'b11
   } scl_twi_e;

   // first byte read from memory lands in hop1
   function automatic scl_cfg_s bytes_to_cfg(input logic [31:0] b);
      return '{ctrl: b[7:0], hop3: b[15:8], hop2: b[23:16],
               hop1: b[31:24]};
   endfunction : bytes_to_cfg

   function automatic logic [6:0] hop_channel(input scl_cfg_s c,
                                              input logic [3:0] idx);
      logic [15:0] sum;
      sum = 16'(c.hop1) + 16'(idx) * 16'(c.hop2) + 16'(c.hop3);
      return 7'(sum % 16'(CH_SPAN));
   endfunction : hop_channel

endpackage : scl_pkg

// ---- scl_clkdiv.sv ----
`timescale 1ns/100ps
module scl_clkdiv
   import scl_pkg::*;
#(
   parameter int DIV = 2
) (
   input  wire logic CLK_SYS,  // system clock
   input  wire logic RESET,    // async reset, high
   output logic      EN        // one-cycle pulse every DIV cycles
);
   localparam int W = $clog2(DIV + 1);
   localparam logic [W-1:0] LAST = W'(DIV - 1);

   logic [W-1:0] cnt;

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         cnt <= '0;
         EN  <= 1'b0;
      end else begin
         cnt <= (cnt == LAST) ? '0 : cnt + 1'b1;
         EN  <= (cnt == LAST);
      end
   end

endmodule : scl_clkdiv

// ---- scl_twi_rd.sv ----
`timescale 1ns/100ps
module scl_twi_rd
   import scl_pkg::*;
(
   input  wire logic            CLK_SYS,    // system clock
   input  wire logic            RESET,      // async reset, high
   input  wire logic            TICK,       // quarter-bit enable
   input  wire logic            START,      // begin probe and read
   input  wire logic            SDA_IN,     // data line level
   output logic                 SCL_OE,     // pull clock low
   output logic                 SDA_OE,     // pull data low
   output logic                 DONE,       // one-cycle end pulse
   output logic                 FOUND,      // memory acknowledged
   output logic [8*NCFG-1:0]    DATA        // bytes, first one high
);
   scl_twi_e    st;
   logic [1:0]  q;
   logic [3:0]  bitn;
   logic [2:0]  byten;
   logic [7:0]  shreg;

   wire addr_phase = (byten == 3'd0);
   wire ack_slot   = (bitn == 4'd8);
   wire last_byte  = (byten == 3'(NCFG));
   wire end_bytes  = ack_slot && ((addr_phase && !FOUND) || last_byte);

   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         st     <= TW_IDLE;
         q      <= 2'd0;
         bitn   <= 4'd0;
         byten  <= 3'd0;
         shreg  <= 8'h00;
         SCL_OE <= 1'b0;
         SDA_OE <= 1'b0;
         DONE   <= 1'b0;
         FOUND  <= 1'b0;
         DATA   <= '0;
      end else begin
         DONE <= 1'b0;
         if (st == TW_IDLE) begin
            if (START) begin
               st    <= TW_START;
               q     <= 2'd0;
               FOUND <= 1'b0;
               shreg <= TWI_DEV_RD;
               bitn  <= 4'd0;
               byten <= 3'd0;
            end
         end else if (TICK) begin
            q <= q + 2'd1;
            unique case (st)
               TW_START: begin
                  if (q == 2'd0) SDA_OE <= 1'b1;
                  if (q == 2'd1) begin
                     SCL_OE <= 1'b1;
                     st     <= TW_BITS;
                     q      <= 2'd0;
                  end
               end
               TW_BITS: begin
                  unique case (q)
                     2'd0: begin
                        if (addr_phase && !ack_slot)
                           SDA_OE <= ~shreg[7];
                        else if (ack_slot && !addr_phase)
                           SDA_OE <= !last_byte;  // nak on last byte
                        else
                           SDA_OE <= 1'b0;
                     end
                     2'd1: SCL_OE <= 1'b0;
                     2'd2: begin
                        if (addr_phase && ack_slot)
                           FOUND <= !SDA_IN;
                        else if (addr_phase)
                           shreg <= {shreg[6:0], 1'b0};
                        else if (!ack_slot)
                           DATA <= {DATA[8*NCFG-2:0], SDA_IN};
                     end
                     2'd3: begin
                        SCL_OE <= 1'b1;
                        if (ack_slot) begin
                           bitn  <= 4'd0;
                           byten <= byten + 3'd1;
                           if (end_bytes) st <= TW_STOP;
                        end else begin
                           bitn <= bitn + 4'd1;
                        end
                     end
                  endcase
               end
               TW_STOP: begin
                  if (q == 2'd0) SDA_OE <= 1'b1;
                  if (q == 2'd1) SCL_OE <= 1'b0;
                  if (q == 2'd2) SDA_OE <= 1'b0;
                  if (q == 2'd3) begin
                     DONE <= 1'b1;
                     st   <= TW_IDLE;
                  end
               end
               default: st <= TW_IDLE;
            endcase
         end
      end
   end

endmodule : scl_twi_rd

// ---- scl_top.sv ----
`timescale 1ns/100ps
//
// Contract
// - bias pin high resets; configure after release
// - probe SPI memory first after reset
// - answering memory supplies all register values
// - no SPI answer: retry on 2-wire master
// - loaded values replace initial register contents
// - otherwise keep hard-coded initial values
// - then start link setup; role from pin
// - idle only while linked and hopping synchronized
// - link break restarts link-locate on both sides
// - channel set from three hop parameters
// - transmitter cycles channels sending search packets
// - one search per channel, then fixed wait
// - transmitter: acknowledge moves locate to sync
// - receiver dwells per channel beyond loop time
// - receiver answers one acknowledge, enters sync
// - transmitter sends start condition for hopping
// - first hop channel is the locate channel
// - power-down stops engine; only sleep timers run
// - timer expiry or pin wakes; restart link
// - sleep timers return to power-down on no peer/audio
// - SPI load at 1 MHz, mode 0
// - 2-wire load at 100 kHz
// - master SPI pins high in reset; others inputs
module scl_top
   import scl_pkg::*;
#(
   parameter int DWELL  = DWELL_CYC,    // receiver dwell, cycles
   parameter int LF_DIV = LF_TICK_CYC   // low-rate tick divide
) (
   input  wire logic       CLK_SYS,              // 250 MHz clock
   input  wire logic       RESET,                // power-on reset
   input  wire logic       BIAS_RESET_PIN,       // high forces reset
   input  wire logic       ROLE_SELECT,          // 1 transmitter role
   output logic            MASTER_CHIP_SELECT_N, // memory select
   output logic            MASTER_SERIAL_CLOCK,  // memory clock
   output logic            MASTER_DATA_OUT,      // memory data out
   input  wire logic       MASTER_DATA_IN,       // memory data in
   output logic            TWI_SCL_OUT_EN,       // pull clock low
   output logic            TWI_SDA_OUT_EN,       // pull data low
   input  wire logic       TWI_SDA_IN,           // data line level
   input  wire logic       CFG_WR,               // slave port write
   input  wire logic [1:0] CFG_IDX,              // byte index
   input  wire logic [7:0] CFG_DATA,             // byte value
   output scl_cfg_s        CFG,                  // live configuration
   output logic            CFG_DONE,             // load finished
   output logic            PINS_OUT_EN,          // other pins may drive
   input  scl_rf_ev_s      RF_RX,                // received packets
   output scl_rf_ev_s      RF_TX,                // packet send pulses
   input  wire logic       LINK_LOST,            // link broke
   input  wire logic       HOP_STEP,             // next hop slot
   output logic [6:0]      RF_CHANNEL,           // radio channel
   output logic            HOP_RUN,              // hopping engine on
   output logic            QOS_RUN,              // service engine on
   output scl_state_e      LINK_STATE,           // controller state
   input  wire logic       AUDIO_PRESENT,        // audio detected
   input  wire logic       WAKE_PIN,             // external wake event
   input  wire logic       POWER_TOGGLE_PIN      // receiver power pin
);
   localparam logic [15:0] ACK_LOAD   = 16'(ACK_WAIT_CYC - 1);
   localparam logic [15:0] DWELL_LOAD = 16'(DWELL - 1);
   localparam logic [6:0]  SPI_LAST   = 7'(SPI_TOTAL_BITS - 1);

   // pin reset joins power-on reset; core stays in reset until both are low
   wire core_rst = RESET | BIAS_RESET_PIN;

   scl_state_e                state;
   scl_state_e                next_state;
   scl_cfg_s                  next_cfg;
   logic                      spi_en;
   logic                      twi_tick;
   logic                      lf_en;
   logic                      spi_started;
   logic                      spi_done;
   logic [6:0]                spi_cnt;
   logic [SPI_CMD_BITS-1:0]   spi_out;
   logic [SPI_TOTAL_BITS-1:0] spi_in;
   logic                      twi_start;
   logic                      twi_done;
   logic                      twi_found;
   logic [8*NCFG-1:0]         twi_data;
   logic [CH_IDX_W-1:0]       ch_idx;
   logic [15:0]               link_cnt;
   logic [15:0]               lf_cnt;
   logic                      tog_prev;
   logic                      tog_armed;

   scl_clkdiv #(.DIV(SPI_HALF_CYC)) u_spi_div (
      .CLK_SYS (CLK_SYS),
      .RESET   (core_rst),
      .EN      (spi_en)
   );

   scl_clkdiv #(.DIV(TWI_QUARTER_CYC)) u_twi_div (
      .CLK_SYS (CLK_SYS),
      .RESET   (core_rst),
      .EN      (twi_tick)
   );

   // stands in for the low-frequency oscillator in power-down
   scl_clkdiv #(.DIV(LF_DIV)) u_lf_div (
      .CLK_SYS (CLK_SYS),
      .RESET   (core_rst),
      .EN      (lf_en)
   );

   scl_twi_rd u_twi (
      .CLK_SYS (CLK_SYS),
      .RESET   (core_rst),
      .TICK    (twi_tick),
      .START   (twi_start),
      .SDA_IN  (TWI_SDA_IN),
      .SCL_OE  (TWI_SCL_OUT_EN),
      .SDA_OE  (TWI_SDA_OUT_EN),
      .DONE    (twi_done),
      .FOUND   (twi_found),
      .DATA    (twi_data)
   );

   // decoding of events and timers
   wire tx_role     = ROLE_SELECT;
   wire mark_ok     = (spi_in[8*NCFG+7:8*NCFG] == MEM_MARK);
   wire spi_loaded  = spi_done && mark_ok;
   wire twi_loaded  = twi_done && twi_found;
   wire sleep_en    = CFG.ctrl[CTRL_SLEEP_EN];
   wire in_search   = (state == ST_LOCATE) || (state == ST_SYNC);
   wire peer_expire = sleep_en && in_search
                      && (lf_cnt == PEER_TIMEOUT_TICKS);
   wire audio_expire = sleep_en && (state == ST_IDLE)
                      && (lf_cnt == AUDIO_TIMEOUT_TICKS);
   wire wake_expire = (lf_cnt == WAKE_PERIOD_TICKS);
   wire pwr_toggle  = tog_armed && !tx_role
                      && (POWER_TOGGLE_PIN != tog_prev);
   wire state_chg   = (next_state != state);
   wire enter_loc   = state_chg && (next_state == ST_LOCATE);
   wire chan_step   = (state == ST_LOCATE) && !state_chg
                      && (link_cnt == 16'h0000);
   wire hop_adv     = (state == ST_IDLE) && HOP_STEP && !state_chg;
   wire sync_go     = tx_role ? 1'b1 : RF_RX.start;
   wire [CH_IDX_W-1:0] ch_next = ch_idx + 1'b1;

   always_comb begin
      next_state = state;
      unique case (state)
         ST_SPI_LOAD:
            if (spi_done)
               next_state = mark_ok ? ST_LOCATE : ST_TWI_LOAD;
         ST_TWI_LOAD:
            if (twi_done) next_state = ST_LOCATE;
         ST_LOCATE:
            if (peer_expire)
               next_state = ST_POWER_DOWN;
            else if (tx_role ? RF_RX.ack : RF_RX.search)
               next_state = ST_SYNC;
         ST_SYNC:
            if (peer_expire)
               next_state = ST_POWER_DOWN;
            else if (sync_go)
               next_state = ST_IDLE;
            else if (link_cnt == 16'h0000)
               next_state = ST_LOCATE;
         ST_IDLE:
            if (LINK_LOST)
               next_state = ST_LOCATE;
            else if (audio_expire)
               next_state = ST_POWER_DOWN;
         ST_POWER_DOWN:
            if (wake_expire || WAKE_PIN)
               next_state = ST_LOCATE;
         default: next_state = ST_SPI_LOAD;
      endcase
      if (pwr_toggle && CFG_DONE)
         next_state = (state == ST_POWER_DOWN) ? ST_LOCATE
                                               : ST_POWER_DOWN;
   end

   // SPI load beats 2-wire load beats slave write; slave writes only after the load phase
   always_comb begin
      next_cfg = CFG;
      if (spi_loaded)
         next_cfg = bytes_to_cfg(spi_in[8*NCFG-1:0]);
      else if (twi_loaded)
         next_cfg = bytes_to_cfg(twi_data);
      else if (CFG_WR && CFG_DONE)
         next_cfg[8*CFG_IDX +: 8] = CFG_DATA;
   end

   always_ff @(posedge CLK_SYS or posedge core_rst) begin
      if (core_rst) begin
         state     <= ST_SPI_LOAD;
         CFG       <= CFG_DEFAULT;
         CFG_DONE  <= 1'b0;
         twi_start <= 1'b0;
      end else begin
         state     <= next_state;
         CFG       <= next_cfg;
         CFG_DONE  <= CFG_DONE || (state_chg && next_state == ST_LOCATE);
         twi_start <= spi_done && !mark_ok;
      end
   end

   // mode 0: data set on falling edge, sampled on rising edge
   always_ff @(posedge CLK_SYS or posedge core_rst) begin
      if (core_rst) begin
         MASTER_CHIP_SELECT_N <= 1'b1;
         MASTER_SERIAL_CLOCK  <= 1'b1;
         MASTER_DATA_OUT      <= 1'b1;
         spi_started <= 1'b0;
         spi_done    <= 1'b0;
         spi_cnt     <= 7'd0;
         spi_out     <= SPI_RD_HDR;
         spi_in      <= '0;
      end else begin
         spi_done <= 1'b0;
         if (state == ST_SPI_LOAD && spi_en && !spi_done) begin
            if (!spi_started) begin
               spi_started          <= 1'b1;
               MASTER_SERIAL_CLOCK  <= 1'b0;
               MASTER_CHIP_SELECT_N <= 1'b0;
               MASTER_DATA_OUT      <= spi_out[SPI_CMD_BITS-1];
               spi_out              <= spi_out << 1;
            end else if (!MASTER_SERIAL_CLOCK) begin
               MASTER_SERIAL_CLOCK <= 1'b1;
               spi_in <= {spi_in[SPI_TOTAL_BITS-2:0], MASTER_DATA_IN};
            end else if (!MASTER_CHIP_SELECT_N) begin
               MASTER_SERIAL_CLOCK <= 1'b0;
               MASTER_DATA_OUT     <= spi_out[SPI_CMD_BITS-1];
               spi_out             <= spi_out << 1;
               spi_cnt             <= spi_cnt + 7'd1;
               if (spi_cnt == SPI_LAST) begin
                  MASTER_CHIP_SELECT_N <= 1'b1;
                  spi_done             <= 1'b1;
               end
            end
         end
      end
   end

   // channel walk and per-channel timers
   always_ff @(posedge CLK_SYS or posedge core_rst) begin
      if (core_rst) begin
         ch_idx     <= '0;
         link_cnt   <= 16'h0000;
         RF_CHANNEL <= 7'h00;
         RF_TX      <= '0;
      end else begin
         RF_TX.search <= chan_step && tx_role;
         RF_TX.ack    <= (state == ST_LOCATE) && !tx_role
                         && RF_RX.search;
         RF_TX.start  <= (state == ST_SYNC) && tx_role;
         if (enter_loc) begin
            ch_idx   <= '1;          // first step wraps to channel 0
            link_cnt <= 16'h0000;
         end else if (chan_step) begin
            ch_idx     <= ch_next;
            RF_CHANNEL <= hop_channel(CFG, ch_next);
            link_cnt   <= tx_role ? ACK_LOAD : DWELL_LOAD;
         end else if (state_chg && next_state == ST_SYNC) begin
            link_cnt <= DWELL_LOAD;  // sync gives up after one dwell
         end else if (hop_adv) begin
            ch_idx     <= ch_next;   // hopping starts at locate channel
            RF_CHANNEL <= hop_channel(CFG, ch_next);
         end else if (link_cnt != 16'h0000) begin
            link_cnt <= link_cnt - 16'h0001;
         end
      end
   end

   // sleep timers count low-rate ticks; restart on every state change
   always_ff @(posedge CLK_SYS or posedge core_rst) begin
      if (core_rst) begin
         lf_cnt    <= 16'h0000;
         tog_prev  <= 1'b0;
         tog_armed <= 1'b0;
      end else begin
         tog_prev  <= POWER_TOGGLE_PIN;
         tog_armed <= 1'b1;
         if (state_chg || (state == ST_IDLE && AUDIO_PRESENT))
            lf_cnt <= 16'h0000;
         else if (lf_en && lf_cnt != 16'hffff)
            lf_cnt <= lf_cnt + 16'h0001;
      end
   end

   assign QOS_RUN     = (state != ST_POWER_DOWN);
   assign HOP_RUN     = (state == ST_IDLE);
   assign PINS_OUT_EN = CFG_DONE;
   assign LINK_STATE  = state;

endmodule : scl_top

// ---- scl_mem_model.sv ----
`timescale 1ns/100ps
module scl_mem_model (
   input  wire logic        clk,     // system clock
   input  wire logic        present, // memory fitted
   input  wire logic [39:0] image,   // marker, then bytes
   input  wire logic        cs_n,    // select, low
   input  wire logic        sck,     // serial clock
   input  wire logic        mosi,    // data from master
   output logic             miso,    // data to master
   output logic [23:0]      hdr      // command seen
);
   int   cnt = 0;
   int   k   = 0;
   logic fl  = 1'h0;
   // an absent or idle memory leaves the line wandering
   always @(posedge clk) fl <= ~fl;
   always @(posedge sck or posedge cs_n)
      if (cs_n) cnt <= 0;
      else begin
         cnt <= cnt + 1;
         if (cnt < 24) hdr <= {hdr[22:0], mosi};
      end
   // mode 0: next bit set on the falling clock edge
   always @(negedge sck or posedge cs_n)
      if (cs_n) k <= 0;
      else if (cnt > 24) k <= k + 1;
   assign miso = (present && !cs_n) ? image[39 - k] : fl;
endmodule : scl_mem_model

// ---- scl_top_sva.sv ----
`timescale 1ns/100ps
module scl_top_sva
   import scl_pkg::*;
(
   input wire logic       CLK_SYS,              // clock
   input wire logic       RESET,                // reset
   input wire logic       BIAS_RESET_PIN,       // pin reset
   input wire logic       ROLE_SELECT,          // role
   input wire logic       MASTER_CHIP_SELECT_N, // select
   input wire logic       MASTER_SERIAL_CLOCK,  // clock out
   input wire logic       MASTER_DATA_OUT,      // data out
   input wire logic       PINS_OUT_EN,          // pins drive
   input wire scl_cfg_s   CFG,                  // config
   input wire scl_rf_ev_s RF_RX,                // rx events
   input wire scl_rf_ev_s RF_TX,                // tx events
   input wire logic       LINK_LOST,            // link broke
   input wire logic [6:0] RF_CHANNEL,           // channel
   input wire logic       HOP_RUN,              // hopping on
   input wire logic       QOS_RUN,              // engine on
   input wire scl_state_e LINK_STATE            // state
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET || BIAS_RESET_PIN);
   logic [8:0] ch0;
   logic       tx_loc;
   assign ch0    = (9'(CFG.hop1) + 9'(CFG.hop3)) % 9'h50;
   assign tx_loc = ROLE_SELECT && LINK_STATE == ST_LOCATE;
   sequence rx_answer;
      RF_TX.ack ##[0:1] LINK_STATE == ST_SYNC;
   endsequence
   chk_reset_pins: assert property (
      disable iff (1'h0) (RESET || BIAS_RESET_PIN) |-> MASTER_CHIP_SELECT_N
      && MASTER_SERIAL_CLOCK && MASTER_DATA_OUT && !PINS_OUT_EN)
      else $error("master pins not idle in reset");
   chk_hop_idle: assert property (
      HOP_RUN == (LINK_STATE == ST_IDLE)) else $error("hop flag wrong");
   chk_qos_pdown: assert property (
      QOS_RUN == (LINK_STATE != ST_POWER_DOWN)) else $error("qos flag wrong");
   chk_locate_first: assert property (
      ROLE_SELECT && $rose(LINK_STATE == ST_LOCATE) |-> ##[0:1]
      (RF_TX.search && RF_CHANNEL == ch0[6:0])) else $error("bad first search");
   chk_search_gap: assert property (
      RF_TX.search |=> !RF_TX.search [*8]) else $error("searches too close");
   chk_search_next: assert property (
      tx_loc && RF_TX.search |-> ##[1:600] (RF_TX.search || !tx_loc))
      else $error("search stalled");
   chk_ack_sync: assert property (
      tx_loc && RF_RX.ack |-> ##[1:2] LINK_STATE == ST_SYNC)
      else $error("ack did not sync");
   chk_sync_start: assert property (
      ROLE_SELECT && $rose(LINK_STATE == ST_SYNC) |-> ##[0:2] RF_TX.start)
      else $error("no start sent");
   chk_rx_answer: assert property (
      !ROLE_SELECT && LINK_STATE == ST_LOCATE && RF_RX.search |=> rx_answer)
      else $error("receiver did not answer");
   chk_lost_locate: assert property (
      LINK_STATE == ST_IDLE && LINK_LOST |-> ##[1:2] LINK_STATE == ST_LOCATE)
      else $error("lost link not relocated");
   chk_spi_mode0: assert property (
      $fell(MASTER_CHIP_SELECT_N) |-> !MASTER_SERIAL_CLOCK [*8])
      else $error("clock not idle low");
endmodule : scl_top_sva
bind scl_top scl_top_sva scl_top_sva_i (.*);

// ---- testbench.sv ----
`timescale 1ns/100ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin errors++; \
   $display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
   import scl_pkg::*;
   logic       CLK_SYS = 0, RESET = 0, BIAS_RESET_PIN = 0, ROLE_SELECT = 1;
   logic       CFG_WR = 0, LINK_LOST = 0, HOP_STEP = 0, AUDIO_PRESENT = 1;
   logic       WAKE_PIN = 0, POWER_TOGGLE_PIN = 0, present = 1;
   logic       MASTER_CHIP_SELECT_N, MASTER_SERIAL_CLOCK, MASTER_DATA_OUT;
   logic       MASTER_DATA_IN, TWI_SCL_OUT_EN, TWI_SDA_OUT_EN, TWI_SDA_IN;
   logic       CFG_DONE, PINS_OUT_EN, HOP_RUN, QOS_RUN;
   logic       start_seen = 0, twi_seen = 0;
   logic [1:0] CFG_IDX = 0;
   logic [7:0] CFG_DATA = 0, b;
   logic [6:0] RF_CHANNEL;
   logic [31:0] exp_cfg;
   logic [23:0] hdr;
   scl_cfg_s   CFG;
   scl_rf_ev_s RF_RX = '0, RF_TX;
   scl_state_e LINK_STATE;
   int         errors = 0, total_checks = 0, seed = 32'h03e6, g;
   wire logic [39:0] image = {MEM_MARK, exp_cfg[7:0], exp_cfg[15:8],
                              exp_cfg[23:16], exp_cfg[31:24]};
   wire logic [3:0]  pins = {MASTER_CHIP_SELECT_N, MASTER_SERIAL_CLOCK,
                             MASTER_DATA_OUT, PINS_OUT_EN};
   // pull-up on the data wire, no memory on the 2-wire bus
   assign TWI_SDA_IN = ~TWI_SDA_OUT_EN;
   scl_top #(.LF_DIV(4)) scl_top_i (.*);
   scl_mem_model scl_mem_model_i (.clk(CLK_SYS), .present(present),
      .image(image), .cs_n(MASTER_CHIP_SELECT_N), .sck(MASTER_SERIAL_CLOCK),
      .mosi(MASTER_DATA_OUT), .miso(MASTER_DATA_IN), .hdr(hdr));
   initial forever #2 CLK_SYS = ~CLK_SYS;
   always @(posedge CLK_SYS) begin
      if (RF_TX.start === 1'h1) start_seen = 1;
      if (TWI_SCL_OUT_EN === 1'h1) twi_seen = 1;
   end
   function automatic int ch(input int i);
      return (exp_cfg[7:0] + i * exp_cfg[15:8] + exp_cfg[23:16]) % CH_SPAN;
   endfunction : ch
   task cyc(input int n);
      repeat (n) @(posedge CLK_SYS);
      #1;
   endtask : cyc
   task wait_done;
      for (g = 0; g < 60000 && CFG_DONE !== 1'h1; g++) cyc(1);
   endtask : wait_done
   task wait_search;
      for (g = 0; g < 2000 && RF_TX.search !== 1'h1; g++) cyc(1);
   endtask : wait_search
   task summarize;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : summarize
   // whole run is about 60000 cycles
   initial begin
      #360000;
      errors++;
      summarize;
   end
   initial begin
      // a real edge on the async reset, not a time-zero initial value
      RESET <= 1;
      exp_cfg = $random(seed);
      exp_cfg[24] = 1'h0; // sleep timers off
      cyc(12);
      `CHK("rst_pins", 4'he, pins)
      `CHK("cfg_rst", CFG_DEFAULT, CFG)
      @(posedge CLK_SYS) RESET <= 0;
      wait_done;
      `CHK("spi_hdr", SPI_RD_HDR, hdr)
      `CHK("no_twi", 1'h0, twi_seen)
      `CHK("cfg_mem", exp_cfg, CFG)
      `CHK("pins_on", 1'h1, PINS_OUT_EN)
      wait_search;
      `CHK("ch0", 7'(ch(0)), RF_CHANNEL)
      cyc(1);
      wait_search;
      `CHK("gap", 1'h1, g + 1 >= ACK_WAIT_CYC && g < ACK_WAIT_CYC + 2)
      `CHK("ch1", 7'(ch(1)), RF_CHANNEL)
      @(posedge CLK_SYS) RF_RX.ack <= 1'h1;
      @(posedge CLK_SYS) RF_RX.ack <= 1'h0;
      for (g = 0; g < 50 && LINK_STATE !== ST_IDLE; g++) cyc(1);
      `CHK("tx_idle", ST_IDLE, LINK_STATE)
      cyc(1);
      `CHK("start", 1'h1, start_seen)
      `CHK("hop_on", 1'h1, HOP_RUN)
      `CHK("ch_first", 7'(ch(1)), RF_CHANNEL)
      @(posedge CLK_SYS) HOP_STEP <= 1;
      @(posedge CLK_SYS) HOP_STEP <= 0;
      cyc(2);
      `CHK("ch_next", 7'(ch(2)), RF_CHANNEL)
      for (int i = 0; i < 4; i++) begin
         b = 8'($random(seed)) & 8'hfe;
         @(posedge CLK_SYS);
         CFG_WR <= 1;
         CFG_IDX <= 2'(i);
         CFG_DATA <= b;
         exp_cfg[8*i +: 8] = b;
      end
      @(posedge CLK_SYS) CFG_WR <= 0;
      cyc(1);
      `CHK("cfg_wr", exp_cfg, CFG)
      @(posedge CLK_SYS) LINK_LOST <= 1;
      @(posedge CLK_SYS) LINK_LOST <= 0;
      cyc(1);
      `CHK("relocate", ST_LOCATE, LINK_STATE)
      present = 0;
      twi_seen = 0;
      @(posedge CLK_SYS) BIAS_RESET_PIN <= 1;
      ROLE_SELECT <= 0;
      cyc(12);
      `CHK("bias_rst", CFG_DEFAULT, CFG)
      @(posedge CLK_SYS) BIAS_RESET_PIN <= 0;
      wait_done;
      cyc(2);
      `CHK("twi_try", 1'h1, twi_seen)
      `CHK("twi_free", 2'h0, {TWI_SCL_OUT_EN, TWI_SDA_OUT_EN})
      `CHK("cfg_dflt", CFG_DEFAULT, CFG)
      `CHK("rx_loc", ST_LOCATE, LINK_STATE)
      @(posedge CLK_SYS) RF_RX.search <= 1'h1;
      @(posedge CLK_SYS) RF_RX.search <= 1'h0;
      #1;
      `CHK("rx_ack", 1'h1, RF_TX.ack)
      cyc(1);
      `CHK("rx_sync", ST_SYNC, LINK_STATE)
      @(posedge CLK_SYS) RF_RX.start <= 1'h1;
      @(posedge CLK_SYS) RF_RX.start <= 1'h0;
      cyc(1);
      `CHK("rx_idle", ST_IDLE, LINK_STATE)
      @(posedge CLK_SYS) POWER_TOGGLE_PIN <= 1;
      cyc(3);
      `CHK("pdown", ST_POWER_DOWN, LINK_STATE)
      `CHK("qos_off", 1'h0, QOS_RUN)
      @(posedge CLK_SYS) WAKE_PIN <= 1;
      @(posedge CLK_SYS) WAKE_PIN <= 0;
      cyc(2);
      `CHK("wake", ST_LOCATE, LINK_STATE)
      summarize;
   end
endmodule : testbench
